// ===== logic/fault_pkg.sv
// fault_pkg: timing counts, register map, status layout and types of the fault manager
// assumes: a single 50 MHz clk_sys domain and software access over APB
package fault_pkg;

	// ==================================================================
	// timing
	localparam int T_CLK_NS    = 20;          // clk_sys period
	localparam int SYNC_CYC    = 3;           // pin synchroniser latency
	localparam int LAT_SLOW_NS = 950_000;     // temperature and input voltage
	localparam int LAT_MID_NS  = 525_000;     // input current and input power
	localparam int LAT_OC_NS   = 175_000;     // total output current
	localparam int LAT_FAST_NS = 1_000;       // stage fault, stage not ready
	localparam int HIC_NS      = 20_000_000;  // hiccup wait before retry
	localparam int SLOW_CYC    = LAT_SLOW_NS / T_CLK_NS - SYNC_CYC;
	localparam int MID_CYC     = LAT_MID_NS / T_CLK_NS - SYNC_CYC;
	localparam int OC_CYC      = LAT_OC_NS / T_CLK_NS - SYNC_CYC;
	localparam int FAST_CYC    = LAT_FAST_NS / T_CLK_NS - SYNC_CYC - 2;
	localparam int HIC_CYC     = HIC_NS / T_CLK_NS;

	// ==================================================================
	// sizes
	localparam int NRAIL   = 2;
	localparam int NPHASE  = 12;
	localparam int NSTAT   = 22;
	localparam int N_SLOW  = 8;
	localparam int N_MID   = 3;
	localparam int N_FAST  = 7;
	localparam int ADDR_W  = 8;

	// ==================================================================
	// register byte offsets
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_RESP   = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_MASK   = 8'h0C;
	localparam logic [7:0] A_STATE  = 8'h10;
	localparam logic [7:0] A_OCLIM  = 8'h14;
	localparam logic [7:0] A_OCTOT  = 8'h18;
	localparam logic [7:0] A_TOFF   = 8'h1C;

	// ==================================================================
	// fields and reset values
	localparam int C_EN = 0;                        // rail enables [1:0]
	localparam int C_CLR = 8;                       // clear faults, write one
	localparam int RF_OT = 0, RF_STG = 2, RF_OC = 4; // response slots, +rail
	localparam int RF_IN_OV = 6, RF_IN_UV = 7, RF_IIN_OC = 8;
	localparam logic [1:0] RSP_IGNORE = 2'h0;
	localparam logic [1:0] RSP_LATCH  = 2'h1;
	localparam logic [1:0] RSP_HICCUP = 2'h2;
	localparam logic [17:0] RESP_RST  = 18'h1_5555;  // every slot latch-off
	localparam int OCL_PH_LSB = 16;
	localparam int OCL_PG_BIT = 24;
	localparam logic [7:0] PHASE_ALL  = 8'hFF;
	localparam logic [9:0] OC_TOT_RST = 10'h3FF;
	localparam logic [7:0] PH_LIM_RST = 8'h82;

	// ==================================================================
	// status bit positions; paged entries take one bit per rail
	localparam int S_OT_F = 0, S_OT_W = 2, S_STG = 4, S_NRDY = 6, S_OC = 8, S_OCL = 10;
	localparam int S_IN_OV_F = 12, S_IN_OV_W = 13, S_IN_UV_W = 14, S_IN_UV_F = 15;
	localparam int S_IIN_F = 16, S_IIN_W = 17, S_PIN_W = 18;
	localparam int S_ADDR = 19, S_BOOT = 20, S_CML = 21;
	localparam logic [21:0] RAIL_MASK_A = 22'h00_0555;
	localparam logic [21:0] RAIL_MASK_B = 22'h00_0AAA;
	localparam logic [21:0] STRAP_MASK  = 22'h18_0000;

	// ==================================================================
	// rail sequencer states, gray along off, run, stop, hiccup, latch
	typedef enum logic [2:0] {
		R_OFF  = 3'h0,
		R_RUN  = 3'h1,
		R_STOP = 3'h3,
		R_HIC  = 3'h2,
		R_LAT  = 3'h6
	} rail_e;

endpackage

// ===== logic/cond_if.sv
// cond_if: raw comparator levels into a qualifier and the qualified levels back
// assumes: qual side on clk_sys; raw levels may be asynchronous
interface cond_if #(parameter int W = 1);
	logic [W-1:0] raw;   // unsynchronised comparator levels
	logic [W-1:0] qual;  // levels that have persisted long enough
	modport filt (input raw, output qual);
	modport drive (output raw, input qual);
endinterface

// ===== logic/cond_qualify.sv
// cond_qualify: synchronises comparator levels and qualifies them by persistence
// assumes: raw inputs are asynchronous; LIMIT counts fit in 16 bits
module cond_qualify #(
	parameter int W     = 1,
	parameter int LIMIT = 1
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic nrst,
	// levels in and out
	cond_if.filt      cif
);
	localparam logic [15:0] LIM16 = 16'(LIMIT);

	logic [W-1:0] s1_q, s2_q, s3_q; // three-stage synchroniser
	logic [W-1:0] lvl_q;            // level once stages two and three agree
	logic [W-1:0] qual_q;           // qualified level
	logic [15:0]  cnt_q [W];        // persistence counters

	// ==================================================================
	// synchroniser; stage one feeds only stage two
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			lvl_q <= '0;
		end else begin
			s1_q  <= cif.raw;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			// hold while the two late stages disagree, to reject a single glitch
			lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
		end
	end

	// ==================================================================
	// persistence count; a drop clears at once so recovery is never delayed
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			qual_q <= '0;
			for (int i = 0; i < W; i++) cnt_q[i] <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (!lvl_q[i]) begin
					cnt_q[i]  <= '0;
					qual_q[i] <= 1'b0;
				end else if (cnt_q[i] == LIM16) begin
					qual_q[i] <= 1'b1;
				end else begin
					cnt_q[i] <= cnt_q[i] + 16'h0001;
				end
			end
		end
	end

	assign cif.qual = qual_q;

endmodule // cond_qualify

// ===== logic/regulator_fault_manager.sv
// regulator_fault_manager: fault detection, response and clearing for two rails
// assumes: comparator levels arrive asynchronous; init_done, strap checks and
// cml_error come from logic on clk_sys; nrst is the logic supply power cycle

// How it works
// - shutdown response drops regulator ready
// - faults set status, alert unless masked
// - clears hold only once condition is gone
// - phase all-ones writes page total threshold
// - other phase writes that phase limit
// - stage over-temperature armed after init, selectable
// - stage not ready flagged fast, tristates rail
// - stage not ready blocks rail start-up
// - fault shutdown skips the turn-off delay
// - tristate immediately, before status and alert
module regulator_fault_manager #(
	parameter int SLOW_CYC_P = fault_pkg::SLOW_CYC, // 950 us qualification
	parameter int MID_CYC_P  = fault_pkg::MID_CYC,  // 525 us qualification
	parameter int OC_CYC_P   = fault_pkg::OC_CYC,   // 175 us qualification
	parameter int HIC_CYC_P  = fault_pkg::HIC_CYC   // hiccup retry wait
) (
	// clock and reset
	input  wire logic                             clk_sys,
	input  wire logic                             nrst,
	// apb slave
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [fault_pkg::ADDR_W-1:0]     paddr,
	input  wire logic [31:0]                      pwdata,
	output logic      [31:0]                      prdata,
	output logic                                  pready,
	output logic                                  pslverr,
	// device state from the controller core
	input  wire logic                             init_done,
	input  wire logic                             addr_strap_bad,
	input  wire logic                             boot_strap_bad,
	input  wire logic                             cml_error,
	// per-rail comparator levels
	input  wire logic [fault_pkg::NRAIL-1:0]      stage_temp_fault_line_hi,
	input  wire logic [fault_pkg::NRAIL-1:0]      stage_temp_fault_line_lo,
	input  wire logic [fault_pkg::NRAIL-1:0]      stage_ot_fault,
	input  wire logic [fault_pkg::NRAIL-1:0]      stage_ot_warn,
	input  wire logic [fault_pkg::NRAIL-1:0]      iout_oc_hit,
	input  wire logic [fault_pkg::NRAIL-1:0]      phase_current_limit_hit,
	// shared input-side comparator levels
	input  wire logic                             in_ov_flt_cmp,
	input  wire logic                             in_ov_warn_cmp,
	input  wire logic                             in_uv_warn_cmp,
	input  wire logic                             in_uv_flt_cmp,
	input  wire logic                             input_turn_on_level_cmp,
	input  wire logic                             iin_oc_flt_cmp,
	input  wire logic                             iin_oc_warn_cmp,
	input  wire logic                             pin_op_warn_cmp,
	// rail control
	output logic      [fault_pkg::NRAIL-1:0]      pwm_enable,
	output logic      [fault_pkg::NRAIL-1:0]      pwm_tristate,
	output logic      [fault_pkg::NRAIL-1:0]      regulator_ready_out,
	// host signalling
	output logic                                  fault_flag_out_n,
	output logic                                  smbalert_n,
	output logic                                  irq,
	// thresholds to the current comparators
	output logic      [9:0]                       oc_total_thr_a,
	output logic      [9:0]                       oc_total_thr_b,
	output logic      [fault_pkg::NPHASE*8-1:0]   phase_current_limit_thr
);
	import fault_pkg::*;

	// ==================================================================
	// qualifier channels
	cond_if #(.W(N_SLOW))  slow_c ();  // ot fault/warn, input ov/uv
	cond_if #(.W(N_MID))   mid_c ();   // input current and power
	cond_if #(.W(NRAIL))   oc_c ();    // total output current
	cond_if #(.W(N_FAST))  fast_c ();  // stage fault, not ready, ocl, turn-on

	assign slow_c.raw = {in_uv_flt_cmp, in_uv_warn_cmp, in_ov_warn_cmp, in_ov_flt_cmp,
	                     stage_ot_warn, stage_ot_fault};
	assign mid_c.raw  = {pin_op_warn_cmp, iin_oc_warn_cmp, iin_oc_flt_cmp};
	assign oc_c.raw   = iout_oc_hit;
	assign fast_c.raw = {input_turn_on_level_cmp, phase_current_limit_hit,
	                     stage_temp_fault_line_lo, stage_temp_fault_line_hi};

	cond_qualify #(.W(N_SLOW), .LIMIT(SLOW_CYC_P)) u_slow (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.cif     (slow_c)
	);
	cond_qualify #(.W(N_MID), .LIMIT(MID_CYC_P)) u_mid (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.cif     (mid_c)
	);
	cond_qualify #(.W(NRAIL), .LIMIT(OC_CYC_P)) u_oc (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.cif     (oc_c)
	);
	cond_qualify #(.W(N_FAST), .LIMIT(FAST_CYC)) u_fast (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.cif     (fast_c)
	);

	// ==================================================================
	// state
	logic [NRAIL-1:0]  en_q;          // rail enables from software
	logic [NRAIL-1:0]  en_prev_q;     // for enable-cycle edges
	logic [17:0]       resp_q;        // response slots, two bits each
	logic [NSTAT-1:0]  status_q;      // sticky event bits
	logic [NSTAT-1:0]  mask_q;        // one masks the alert
	logic [15:0]       toff_q;        // turn-off delay in clk_sys cycles
	logic [9:0]        tot_q [NRAIL]; // total overcurrent thresholds
	logic [7:0]        ph_q [NPHASE]; // per-phase current limits
	logic              strap_q;       // pinstrap lock, power cycle only
	logic              uv_armed_q;    // input undervoltage armed
	logic              init_q;        // init_done delayed, for its edge
	rail_e             st_q [NRAIL];  // rail sequencers
	logic [19:0]       tmr_q [NRAIL]; // turn-off and hiccup timers
	logic [NRAIL-1:0]  ready_q;
	logic              flag_q;
	logic [31:0]       prdata_q;

	// ==================================================================
	// combinational terms
	logic              wr_acc;        // write access phase
	logic              clr_all;       // clear-faults command
	logic              strap_chk;     // one cycle at init completion
	logic [NRAIL-1:0]  en_rise;
	logic [NRAIL-1:0]  run;           // rail converting
	logic [NRAIL-1:0]  ot_c, stg_c, nrdy, oc_flt;
	logic              in_ov_c, in_uv_c, iin_oc_c;
	logic [1:0]        act [NRAIL];   // bit0 latch-off, bit1 hiccup
	logic [NSTAT-1:0]  ev;            // events this cycle
	logic [NSTAT-1:0]  clr;           // bits cleared this cycle

	// response request for one condition under one response slot
	function automatic logic [1:0] act_of(input logic c, input logic [1:0] r);
		act_of = {c & (r == RSP_HICCUP), c & (r == RSP_LATCH)};
	endfunction

	// mapped offsets answer without error
	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		addr_ok = a inside {A_CTRL, A_RESP, A_STATUS, A_MASK, A_STATE, A_OCLIM, A_OCTOT, A_TOFF};
	endfunction

	// zero wait states; the read word is latched in the setup cycle
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~addr_ok(paddr);
	assign wr_acc    = psel & penable & pwrite & addr_ok(paddr);
	assign clr_all   = wr_acc & (paddr == A_CTRL) & pwdata[C_CLR];
	assign strap_chk = init_done & ~init_q;
	assign en_rise   = en_q & ~en_prev_q;
	assign prdata    = prdata_q;

	// ==================================================================
	// armed conditions and per-rail response requests
	always_comb begin
		in_ov_c  = init_done & slow_c.qual[4];
		in_uv_c  = uv_armed_q & slow_c.qual[7];
		iin_oc_c = (|run) & mid_c.qual[0];
		for (int r = 0; r < NRAIL; r++) begin
			run[r]    = (st_q[r] == R_RUN) | (st_q[r] == R_STOP);
			ot_c[r]   = init_done & slow_c.qual[r];
			stg_c[r]  = init_done & fast_c.qual[r];
			nrdy[r]   = init_done & fast_c.qual[2+r];
			oc_flt[r] = run[r] & oc_c.qual[r];
			act[r]    = act_of(ot_c[r], resp_q[2*(RF_OT+r) +: 2])
			          | act_of(stg_c[r], resp_q[2*(RF_STG+r) +: 2])
			          | act_of(oc_flt[r], resp_q[2*(RF_OC+r) +: 2])
			          | act_of(in_ov_c, resp_q[2*RF_IN_OV +: 2])
			          | act_of(in_uv_c, resp_q[2*RF_IN_UV +: 2])
			          | act_of(iin_oc_c, resp_q[2*RF_IIN_OC +: 2])
			          | {1'b0, strap_q};
		end
	end

	// ==================================================================
	// pwm control; combinational so a fault tristates in its own cycle,
	// one edge ahead of the status bit and the alert
	always_comb begin
		for (int r = 0; r < NRAIL; r++) begin
			pwm_tristate[r] = ~run[r] | nrdy[r] | (|act[r]);
			pwm_enable[r]   = ~pwm_tristate[r];
		end
	end

	// ==================================================================
	// event vector
	always_comb begin
		ev = '0;
		for (int r = 0; r < NRAIL; r++) begin
			ev[S_OT_F+r] = ot_c[r];
			ev[S_OT_W+r] = init_done & slow_c.qual[2+r];
			ev[S_STG+r]  = stg_c[r];
			ev[S_NRDY+r] = nrdy[r];
			ev[S_OC+r]   = oc_flt[r];
			ev[S_OCL+r]  = run[r] & fast_c.qual[4+r];
		end
		ev[S_IN_OV_F] = in_ov_c;
		ev[S_IN_OV_W] = init_done & slow_c.qual[5];
		ev[S_IN_UV_W] = uv_armed_q & slow_c.qual[6];
		ev[S_IN_UV_F] = in_uv_c;
		ev[S_IIN_F]   = iin_oc_c;
		ev[S_IIN_W]   = (|run) & mid_c.qual[1];
		ev[S_PIN_W]   = (|run) & mid_c.qual[2];
		ev[S_ADDR]    = strap_chk & addr_strap_bad;
		ev[S_BOOT]    = strap_chk & boot_strap_bad;
		ev[S_CML]     = init_done & cml_error;
	end

	// clear sources: write one, clear-faults, enable cycle of a rail;
	// the strap bits are kept out so only a power cycle removes them
	always_comb begin
		clr = '0;
		if (wr_acc && paddr == A_STATUS) clr = pwdata[NSTAT-1:0];
		if (clr_all) clr = '1;
		if (en_rise[0]) clr = clr | RAIL_MASK_A;
		if (en_rise[1]) clr = clr | RAIL_MASK_B;
		clr = clr & ~STRAP_MASK;
	end

	// ==================================================================
	// sticky status; a live condition sets again over the clear
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			status_q <= '0;
		end else begin
			status_q <= (status_q & ~clr) | ev;
		end
	end

	// alert while any unmasked status bit stands
	assign irq        = |(status_q & ~mask_q);
	assign smbalert_n = ~irq;

	// ==================================================================
	// software configuration
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			en_q   <= '0;
			resp_q <= RESP_RST;
			mask_q <= '0;
			toff_q <= '0;
		end else if (wr_acc) begin
			case (paddr)
				A_CTRL:  en_q   <= pwdata[C_EN +: NRAIL];
				A_RESP:  resp_q <= pwdata[17:0];
				A_MASK:  mask_q <= pwdata[NSTAT-1:0];
				A_TOFF:  toff_q <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// ==================================================================
	// current thresholds; the phase field picks total or per-phase
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int r = 0; r < NRAIL; r++) tot_q[r] <= OC_TOT_RST;
			for (int p = 0; p < NPHASE; p++) ph_q[p] <= PH_LIM_RST;
		end else if (wr_acc && paddr == A_OCLIM) begin
			if (pwdata[OCL_PH_LSB +: 8] == PHASE_ALL) begin
				tot_q[pwdata[OCL_PG_BIT]] <= pwdata[9:0];
			end else begin
				// phase numbers past the last phase are ignored
				for (int p = 0; p < NPHASE; p++) begin
					if (pwdata[OCL_PH_LSB +: 8] == 8'(p)) begin
						ph_q[p] <= pwdata[7:0];
					end
				end
			end
		end
	end

	assign oc_total_thr_a = tot_q[0];
	assign oc_total_thr_b = tot_q[1];
	always_comb begin
		for (int p = 0; p < NPHASE; p++) phase_current_limit_thr[8*p +: 8] = ph_q[p];
	end

	// ==================================================================
	// pinstrap lock, undervoltage arming and edge history
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			strap_q    <= 1'b0;
			uv_armed_q <= 1'b0;
			init_q     <= 1'b0;
			en_prev_q  <= '0;
		end else begin
			init_q    <= init_done;
			en_prev_q <= en_q;
			// checked once; nothing but reset ever releases it
			if (strap_chk && (addr_strap_bad || boot_strap_bad)) strap_q <= 1'b1;
			// arms on the first turn-on crossing with a rail enabled, then stays
			if (fast_c.qual[6] && (|en_q)) uv_armed_q <= 1'b1;
		end
	end

	// ==================================================================
	// rail sequencers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int r = 0; r < NRAIL; r++) begin
				st_q[r]  <= R_OFF;
				tmr_q[r] <= '0;
			end
		end else begin
			for (int r = 0; r < NRAIL; r++) begin
				case (st_q[r])
					R_OFF: begin
						// start only with no stage not-ready and no live fault
						if (en_q[r] && !nrdy[r] && !(|act[r])) st_q[r] <= R_RUN;
					end
					R_RUN, R_STOP: begin
						if (act[r][0]) begin
							st_q[r] <= R_LAT;
						end else if (act[r][1]) begin
							st_q[r]  <= R_HIC;
							tmr_q[r] <= 20'(HIC_CYC_P);
						end else if (st_q[r] == R_RUN) begin
							if (!en_q[r]) begin
								st_q[r]  <= (toff_q == 16'h0000) ? R_OFF : R_STOP;
								tmr_q[r] <= {4'h0, toff_q};
							end
						end else if (en_q[r]) begin
							st_q[r] <= R_RUN;                       // re-enabled mid delay
						end else if (tmr_q[r] <= 20'h0_0001) begin
							st_q[r] <= R_OFF;
						end else begin
							tmr_q[r] <= tmr_q[r] - 20'h0_0001;
						end
					end
					R_HIC: begin
						// retry goes through off, which waits out a live fault
						if (!en_q[r] || tmr_q[r] == 20'h0_0000) begin
							st_q[r] <= R_OFF;
						end else begin
							tmr_q[r] <= tmr_q[r] - 20'h0_0001;
						end
					end
					R_LAT: begin
						if ((clr_all || !en_q[r]) && !strap_q) st_q[r] <= R_OFF;
					end
					default: st_q[r] <= R_OFF;
				endcase
			end
		end
	end

	// ==================================================================
	// ready and fault flag; ready falls on the edge a shutdown begins
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ready_q <= '0;
			flag_q  <= 1'b0;
		end else begin
			for (int r = 0; r < NRAIL; r++) begin
				ready_q[r] <= (st_q[r] == R_RUN) & ~(|act[r]) & ~nrdy[r];
			end
			flag_q <= strap_q | (st_q[0] == R_LAT) | (st_q[0] == R_HIC)
			        | (st_q[1] == R_LAT) | (st_q[1] == R_HIC);
		end
	end

	assign regulator_ready_out = ready_q;
	assign fault_flag_out_n    = ~flag_q;

	// ==================================================================
	// read data, captured in the setup cycle
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prdata_q <= '0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				A_CTRL:   prdata_q <= {30'h0000_0000, en_q};
				A_RESP:   prdata_q <= {14'h0000, resp_q};
				A_STATUS: prdata_q <= {10'h000, status_q};
				A_MASK:   prdata_q <= {10'h000, mask_q};
				A_STATE:  prdata_q <= {20'h0_0000, ready_q, uv_armed_q, strap_q,
				                       1'b0, st_q[1], 1'b0, st_q[0]};
				A_OCTOT:  prdata_q <= {6'h00, tot_q[1], 6'h00, tot_q[0]};
				A_TOFF:   prdata_q <= {16'h0000, toff_q};
				default:  prdata_q <= '0;
			endcase
		end
	end

endmodule // regulator_fault_manager

// ===== sim/rfm_properties.sv
// rfm_properties: port-level checks of the fault manager
// assumes: bound into regulator_fault_manager, one clk_sys domain
module rfm_properties (
	// clock, reset and apb
	input wire logic                         clk_sys,
	input wire logic                         nrst,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic [fault_pkg::ADDR_W-1:0] paddr,
	input wire logic                         pslverr,
	// rails and host
	input wire logic [fault_pkg::NRAIL-1:0]  pwm_enable,
	input wire logic [fault_pkg::NRAIL-1:0]  pwm_tristate,
	input wire logic [fault_pkg::NRAIL-1:0]  regulator_ready_out,
	input wire logic                         fault_flag_out_n,
	input wire logic                         smbalert_n,
	input wire logic                         irq
);
	import fault_pkg::*;
	// ==================================================================
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// a rail may only come up from a cycle in which its outputs were driven
	property p_rise(int r);
		$rose(regulator_ready_out[r]) |-> !$past(pwm_tristate[r]);
	endproperty
	a_alert_irq: assert property (smbalert_n == !irq) else $error("alert differs");
	a_pwm_pair: assert property (pwm_enable == ~pwm_tristate) else $error("pwm pair");
	a_ready_drop: assert property ((regulator_ready_out & $past(pwm_tristate)) == 0)
		else $error("ready kept after tristate");
	a_rise_a: assert property (p_rise(0)) else $error("rail a rose while off");
	a_rise_b: assert property (p_rise(1)) else $error("rail b rose while off");
	a_flag_tri: assert property ($fell(fault_flag_out_n) |-> pwm_tristate != 0)
		else $error("flag without tristate");
	a_slverr_map: assert property (psel && penable && paddr > 8'h1C |-> pslverr)
		else $error("unmapped access accepted");
	a_slverr_why: assert property (pslverr |-> psel && penable) else $error("stray slverr");
	// main scenarios
	c_latch: cover property ($fell(fault_flag_out_n));
	c_err: cover property (pslverr);
	c_irq: cover property ($rose(irq));
endmodule // rfm_properties

bind regulator_fault_manager rfm_properties i_props (.*);

// ===== sim/stage_model.sv
// stage_model: two smart power stages on their shared temperature and fault lines
// assumes: the bench commands each state; lines are seen as two comparator levels
module stage_model (
	// clock and bench commands
	input wire logic       clk_sys,
	input wire logic [1:0] nrdy,
	input wire logic [1:0] sfl,
	// line levels: above the fault level, pulled low
	output logic     [1:0] line_hi = 2'b00,
	output logic     [1:0] line_lo = 2'b00
);
	timeunit 1ns;
	timeprecision 1ns;
	// a stage not ready holds its line low, which wins over a fault drive
	always @(posedge clk_sys) begin
		line_lo <= nrdy;
		line_hi <= sfl & ~nrdy;
	end
endmodule // stage_model

// ===== sim/tb_top.sv
// tb_top: self-checking bench of the fault manager with a stage model
// assumes: shortened qualification counts; apb master on clk_sys
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import fault_pkg::*;
	localparam int SLOW = 20;                      // shortened slow count
	logic        clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic        init_done = 0, cml_error = 0, ton = 0, pready, pslverr, irq;
	logic        fault_flag_out_n, smbalert_n;
	logic [7:0]  paddr = 0, wn = 0;                // wn: warning comparators
	logic [31:0] pwdata = 0, prdata, rd, s = 32'h0001_771B;
	logic [1:0]  strap = 0, stage_ot_fault = 0, nrdy = 0, sfl = 0, lhi, llo;
	logic [1:0]  pwm_enable, pwm_tristate, rdy;
	logic [9:0]  oc_total_thr_a, oc_total_thr_b;
	logic [95:0] phase_current_limit_thr;
	wire  [3:0]  ev = {rdy[1], pwm_tristate[1], rdy[0], pwm_tristate[0]};
	int          n_errors = 0, samples_checked = 0, cnt, p;
	always #10 clk_sys = ~clk_sys;
	regulator_fault_manager #(.SLOW_CYC_P(SLOW), .MID_CYC_P(20), .OC_CYC_P(20), .HIC_CYC_P(50))
		i_dut (.*, .addr_strap_bad(strap[0]), .boot_strap_bad(strap[1]), .regulator_ready_out(rdy),
		.stage_temp_fault_line_hi(lhi), .stage_temp_fault_line_lo(llo), .iout_oc_hit(sfl),
		.stage_ot_warn(wn[1:0]), .phase_current_limit_hit(wn[3:2]), .in_ov_warn_cmp(wn[4]),
		.in_uv_warn_cmp(wn[5]), .iin_oc_warn_cmp(wn[6]), .pin_op_warn_cmp(wn[7]),
		.in_ov_flt_cmp(1'b0), .in_uv_flt_cmp(1'b0), .iin_oc_flt_cmp(1'b0),
		.input_turn_on_level_cmp(ton));
	stage_model i_stage (.clk_sys, .nrdy, .sfl, .line_hi(lhi), .line_lo(llo));
	// ==================================================================
	// lfsr step for random stimulus
	function automatic logic [31:0] nx(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(logic [31:0] a, logic [31:0] b);
		samples_checked++;
		if (a !== b) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, a, b);
		end
	endtask
	// apb transfer; returns at the sampling edge so later stimulus lands on an edge
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int i;
		i = 0;
		@(posedge clk_sys);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk_sys);
		penable <= 1;
		do @(posedge clk_sys); while (pready !== 1'b1 && ++i < 50);
		{er, rd} = {pslverr, prdata};
		{psel, penable} <= 2'b00;
		chk(pready, 1);
		if (pready !== 1'b1) finish_test();
	endtask
	// bounded wait for one rail signal, cycles counted in cnt
	task automatic wfor(int k, logic v, int lim);
		cnt = 0;
		while (ev[k] !== v && cnt < lim) begin
			@(posedge clk_sys);
			cnt++;
		end
		chk(ev[k], v);
		if (ev[k] !== v) finish_test();
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		nrst <= 1;
		apb(0, 8'h20, 0);
		chk({er, rd[30:0]}, 32'h8000_0000);
		{init_done, ton} <= 2'b11;
		apb(1, A_CTRL, 1);
		wfor(1, 1, 200);
		repeat (50) @(posedge clk_sys); // turn-on level must qualify
		apb(0, A_STATE, 0);
		chk(rd[11:0], 12'h601);
		// over-temperature on rail a, latch-off by default
		stage_ot_fault[0] <= 1;
		wfor(0, 1, 60);
		chk(cnt >= SLOW - 2 && cnt <= SLOW + 9, 1);
		apb(0, A_STATE, 0);
		chk({rd[2:0], rdy[0], irq, smbalert_n}, 6'h32);
		apb(1, A_STATUS, 1);
		apb(0, A_STATUS, 0);
		chk(rd[0], 1);
		stage_ot_fault[0] <= 0;
		repeat (6) @(posedge clk_sys);
		apb(1, A_STATUS, 32'h003F_FFFF);
		apb(1, A_CTRL, 32'h0000_0101);
		wfor(1, 1, 200);
		apb(0, A_STATUS, 0);
		chk(rd, 0);
		// masked event still sets its status bit
		apb(1, A_MASK, 32'h003F_FFFF);
		cml_error <= 1;
		@(posedge clk_sys);
		cml_error <= 0;
		apb(0, A_STATUS, 0);
		chk({rd[21], irq}, 2'b10);
		apb(1, A_MASK, 0);
		@(posedge clk_sys);
		chk(smbalert_n, 0);
		repeat (4) begin
			s = nx(s);
			p = s[19:16] % 12;
			apb(1, A_OCLIM, {7'h0, s[0], 8'hFF, 6'h0, s[13:4]});
			apb(1, A_OCLIM, {8'h0, 8'(p), 8'h0, s[27:20]});
			wn <= s[31:24];
			@(posedge clk_sys);
			chk(s[0] ? oc_total_thr_b : oc_total_thr_a, s[13:4]);
			chk(phase_current_limit_thr[8*p+:8], s[27:20]);
		end
		// stage b not ready blocks its start, then drops a running rail
		nrdy[1] <= 1;
		repeat (60) @(posedge clk_sys);
		apb(1, A_CTRL, 3);
		repeat (60) begin
			@(posedge clk_sys);
			chk(ev[3:2], 2'b01);
		end
		nrdy[1] <= 0;
		wfor(3, 1, 200);
		nrdy[1] <= 1;
		wfor(2, 1, 100);
		chk(cnt <= 52, 1);
		// stage fault and rail a overcurrent together during a long turn-off delay; the overcurrent acts first
		apb(1, A_TOFF, 32'h0000_FFFF);
		apb(1, A_CTRL, 0);
		@(posedge clk_sys);
		chk(pwm_tristate[0], 0);
		sfl[0] <= 1;
		wfor(0, 1, 100);
		chk(cnt <= 52, 1);
		// second power cycle with bad address and boot straps
		{nrst, init_done, sfl, strap} <= 6'b00_0011;
		repeat (2) @(posedge clk_sys);
		nrst <= 1;
		@(posedge clk_sys);
		init_done <= 1;
		apb(1, A_CTRL, 32'h0000_0103);
		apb(0, A_STATE, 0);
		chk({rd[8], pwm_tristate, fault_flag_out_n}, 4'hE);
		finish_test();
	end
endmodule // tb_top
